//--- src/fcss_bus_if.sv
/*
 * Parallel flash bus between the host controller and the flash device.
 * Assumes both ends share clock_in; all signals are synchronous.
 */
`timescale 1ns/100ps
`default_nettype none
interface fcss_bus_if;
	logic        we;
	logic        re;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport dev  (input we, input re, input addr, input wdata, output rdata);
	modport host (output we, output re, output addr, output wdata, input rdata);
endinterface : fcss_bus_if
`default_nettype wire

//--- src/fcss_device.sv
/*
 * Flash device end: command interpreter, status word, block lock table,
 * one-time area and a timed write state machine with erase suspend.
 * Assumes a host on fcss_bus_if.dev; fault inputs model array outcomes.
 */
// Contract
// RQ1: 0xB0 suspends erase; bit six reports it
// RQ2: Bit seven high when engine idle
// RQ3: Suspended partition accesses avoid erased block
// RQ4: Suspended erase block refuses reads and programs
// RQ5: 0xD0 anywhere resumes suspended erase
// RQ6: 0x70 returns partition to status output
// RQ7: 0x60 setup, confirm to same block
// RQ8: Confirm 0x01 lock, 0xD0 unlock, 0x2F down
// RQ9: After 0x90 lock state on bits 1..0
// RQ10: Lock status at block offset 2
// RQ11: 0xFF returns to array read
// RQ12: OTP program: 0xC0 then data write
// RQ13: OTP address outside area is error
// RQ14: OTP faults set bits three, four, one
// RQ15: Error bits sticky until clear command
// RQ16: Blank check: 0xBC then 0xD0, same block
// RQ17: Blank check: bits 4+5 sequence, 5 not blank
// RQ18: Blank check refused while bit 1 or 3
// RQ19: Host clears status after an error
// RQ20: Host checks full status after blank check
// RQ21: Erase: 0x20 then 0xD0 to block
// RQ22: Bad confirm sets bits four and five
`timescale 1ns/100ps
`default_nettype none
module fcss_device #(
	parameter int ERASE_CYC = fcss_pkg::ERASE_CYC,
	parameter int PROG_CYC  = fcss_pkg::PROG_CYC
) (
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	fcss_bus_if.dev   bus,
	input  wire logic vpp_fault_in,
	input  wire logic prog_fail_in,
	input  wire logic not_blank_in,
	output logic      engine_ready_out,
	output logic      erase_suspended_out
);
	localparam int BW = $clog2(fcss_pkg::NUM_BLK);

	typedef struct packed {
		fcss_pkg::fcss_rmode_t                rmode;
		fcss_pkg::fcss_seq_t                  seq;
		logic [BW-1:0]                        seq_blk;
		fcss_pkg::fcss_wsm_t                  wsm;
		logic [BW-1:0]                        op_blk;
		logic [7:0]                           sr;
		logic [fcss_pkg::NUM_BLK-1:0][1:0]    lock;
		logic                                 otp_locked;
		logic [15:0]                          rdata;
		logic                                 rdy;
		logic                                 susp;
		logic                                 sprog;
	} fcss_dev_t;

	fcss_dev_t s_q;
	fcss_dev_t s_d;
	logic      tmr_start;
	logic      tmr_hold;
	logic      tmr_done;
	logic [fcss_pkg::CNT_W-1:0] tmr_load;
	logic      ptmr_start;
	logic      ptmr_done;

	function automatic logic [BW-1:0] blk_of(input logic [15:0] a);
		blk_of = a[fcss_pkg::BLK_LSB +: BW];
	endfunction : blk_of

	// ****************************************
	// Busy timer
	// ****************************************
	fcss_timer #(.W(fcss_pkg::CNT_W)) u_timer (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.start_in (tmr_start),
		.load_in  (tmr_load),
		.hold_in  (tmr_hold),
		.done_out (tmr_done)
	);
	fcss_timer #(.W(fcss_pkg::CNT_W)) u_ptimer (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.start_in(ptmr_start), .load_in(fcss_pkg::CNT_W'(PROG_CYC)), .hold_in(1'b0),
		.done_out(ptmr_done));

	// ****************************************
	// Command interpreter and engine
	// ****************************************
	always_comb begin
		logic [7:0]    cmd;
		logic [BW-1:0] blk;
		logic          seq_err;
		cmd       = bus.wdata[7:0];
		blk       = blk_of(bus.addr);
		seq_err   = 1'b0;
		s_d       = s_q;
		tmr_start = 1'b0;
		tmr_load  = '0;
		ptmr_start = 1'b0;
		// Engine completion frees the command path first
		if (tmr_done) s_d.wsm = fcss_pkg::FCSS_WSM_IDLE;
		if (ptmr_done) s_d.sprog = 1'b0;
		if (bus.we) begin
			if (s_q.seq != fcss_pkg::FCSS_SEQ_IDLE) begin
				s_d.seq   = fcss_pkg::FCSS_SEQ_IDLE;
				s_d.rmode = fcss_pkg::FCSS_RD_STATUS;
				unique case (s_q.seq)
					fcss_pkg::FCSS_SEQ_ERASE: begin
						if (cmd == fcss_pkg::CMD_CONFIRM && blk == s_q.seq_blk) begin // RQ21
							if (s_q.lock[blk] != fcss_pkg::LK_UNLOCKED)
								s_d.sr[fcss_pkg::SR_LOCKED] = 1'b1;
							else begin
								s_d.wsm    = fcss_pkg::FCSS_WSM_ERASE;
								s_d.op_blk = blk;
								tmr_start  = 1'b1;
								tmr_load   = fcss_pkg::CNT_W'(ERASE_CYC);
							end
						end else seq_err = 1'b1; // RQ22
					end
					fcss_pkg::FCSS_SEQ_LOCK: begin
						s_d.rmode = fcss_pkg::FCSS_RD_ARRAY;
						if (blk != s_q.seq_blk) seq_err = 1'b1; // RQ7
						else if (cmd == fcss_pkg::CMD_LOCK) begin // RQ8
							if (s_q.lock[blk] != fcss_pkg::LK_DOWN) s_d.lock[blk] = fcss_pkg::LK_LOCKED;
						end else if (cmd == fcss_pkg::CMD_CONFIRM) begin // RQ8
							if (s_q.lock[blk] != fcss_pkg::LK_DOWN) s_d.lock[blk] = fcss_pkg::LK_UNLOCKED;
						end else if (cmd == fcss_pkg::CMD_LOCK_DOWN) begin // RQ8
							s_d.lock[blk] = fcss_pkg::LK_DOWN;
						end else seq_err = 1'b1; // RQ22
					end
					fcss_pkg::FCSS_SEQ_OTP: begin
						if (bus.addr < fcss_pkg::OTP_BASE || bus.addr >= fcss_pkg::OTP_TOP)
							s_d.sr[fcss_pkg::SR_PFAIL] = 1'b1; // RQ13
						else if (s_q.otp_locked)
							s_d.sr[fcss_pkg::SR_LOCKED] = 1'b1; // RQ14
						else begin // RQ12
							if (bus.addr == fcss_pkg::OTP_LOCK_ADDR && !bus.wdata[0])
								s_d.otp_locked = 1'b1;
							s_d.wsm   = fcss_pkg::FCSS_WSM_OTP;
							tmr_start = 1'b1;
							tmr_load  = fcss_pkg::CNT_W'(PROG_CYC);
						end
					end
					fcss_pkg::FCSS_SEQ_BLANK: begin
						if (cmd != fcss_pkg::CMD_CONFIRM || blk != s_q.seq_blk)
							seq_err = 1'b1; // RQ17
						else if (s_q.sr[fcss_pkg::SR_LOCKED] || s_q.sr[fcss_pkg::SR_VPP])
							seq_err = 1'b1; // RQ18
						else begin // RQ16
							s_d.wsm   = fcss_pkg::FCSS_WSM_BLANK;
							tmr_start = 1'b1;
							tmr_load  = fcss_pkg::CNT_W'(PROG_CYC);
						end
					end
					fcss_pkg::FCSS_SEQ_PROG: begin
						if (s_q.wsm == fcss_pkg::FCSS_WSM_SUSP && blk == s_q.op_blk)
							seq_err = 1'b1; // RQ4
						else if (s_q.lock[blk] != fcss_pkg::LK_UNLOCKED)
							s_d.sr[fcss_pkg::SR_LOCKED] = 1'b1;
						else if (s_q.wsm == fcss_pkg::FCSS_WSM_SUSP) begin // RQ3
							s_d.sprog  = 1'b1;
							ptmr_start = 1'b1;
						end else begin
							s_d.wsm   = fcss_pkg::FCSS_WSM_PROG;
							tmr_start = 1'b1;
							tmr_load  = fcss_pkg::CNT_W'(PROG_CYC);
						end
					end
					default: ;
				endcase
				if (seq_err) begin
					s_d.sr[fcss_pkg::SR_EBFAIL] = 1'b1; // RQ22
					s_d.sr[fcss_pkg::SR_PFAIL]  = 1'b1; // RQ22
				end
			end else if ((s_d.wsm == fcss_pkg::FCSS_WSM_IDLE
				|| s_d.wsm == fcss_pkg::FCSS_WSM_SUSP) && !s_d.sprog) begin
				s_d.seq_blk = blk;
				unique case (cmd)
					fcss_pkg::CMD_READ_ARRAY:   s_d.rmode = fcss_pkg::FCSS_RD_ARRAY; // RQ11
					fcss_pkg::CMD_READ_STATUS:  s_d.rmode = fcss_pkg::FCSS_RD_STATUS; // RQ6
					fcss_pkg::CMD_IDENT_READ:   s_d.rmode = fcss_pkg::FCSS_RD_IDENT; // RQ9
					fcss_pkg::CMD_STATUS_CLEAR: begin
						s_d.sr[fcss_pkg::SR_EBFAIL] = 1'b0; // RQ15
						s_d.sr[fcss_pkg::SR_PFAIL]  = 1'b0; // RQ15
						s_d.sr[fcss_pkg::SR_VPP]    = 1'b0; // RQ15
						s_d.sr[fcss_pkg::SR_LOCKED] = 1'b0; // RQ15
					end
					fcss_pkg::CMD_CONFIRM: begin
						if (s_q.wsm == fcss_pkg::FCSS_WSM_SUSP) begin // RQ5
							s_d.wsm   = fcss_pkg::FCSS_WSM_ERASE;
							s_d.rmode = fcss_pkg::FCSS_RD_STATUS;
						end
					end
					fcss_pkg::CMD_ERASE_SETUP: begin
						if (s_q.wsm == fcss_pkg::FCSS_WSM_IDLE) s_d.seq = fcss_pkg::FCSS_SEQ_ERASE;
					end
					fcss_pkg::CMD_LOCK_SETUP:  s_d.seq = fcss_pkg::FCSS_SEQ_LOCK; // RQ7
					fcss_pkg::CMD_OTP_SETUP:   s_d.seq = fcss_pkg::FCSS_SEQ_OTP; // RQ12
					fcss_pkg::CMD_BLANK_SETUP: begin
						if (s_q.wsm == fcss_pkg::FCSS_WSM_IDLE) s_d.seq = fcss_pkg::FCSS_SEQ_BLANK;
					end
					fcss_pkg::CMD_PROG_SETUP:  s_d.seq = fcss_pkg::FCSS_SEQ_PROG; // RQ3
					default: ;
				endcase
			end else if (cmd == fcss_pkg::CMD_SUSPEND) begin
				s_d.rmode = fcss_pkg::FCSS_RD_STATUS;
				if (s_q.wsm == fcss_pkg::FCSS_WSM_ERASE && !tmr_done)
					s_d.wsm = fcss_pkg::FCSS_WSM_SUSP; // RQ1
			end else if (cmd == fcss_pkg::CMD_READ_STATUS) begin
				s_d.rmode = fcss_pkg::FCSS_RD_STATUS;
			end
		end
		// Completion flags after the clear command, so a coinciding set wins
		if (tmr_done) begin
			unique case (s_q.wsm)
				fcss_pkg::FCSS_WSM_ERASE: if (vpp_fault_in) s_d.sr[fcss_pkg::SR_VPP] = 1'b1;
				fcss_pkg::FCSS_WSM_PROG, fcss_pkg::FCSS_WSM_OTP: begin
					if (vpp_fault_in) s_d.sr[fcss_pkg::SR_VPP] = 1'b1; // RQ14
					else if (prog_fail_in) s_d.sr[fcss_pkg::SR_PFAIL] = 1'b1; // RQ14
				end
				fcss_pkg::FCSS_WSM_BLANK: if (not_blank_in) s_d.sr[fcss_pkg::SR_EBFAIL] = 1'b1; // RQ17
				default: ;
			endcase
		end
		if (ptmr_done) begin
			if (vpp_fault_in) s_d.sr[fcss_pkg::SR_VPP] = 1'b1; // RQ14
			else if (prog_fail_in) s_d.sr[fcss_pkg::SR_PFAIL] = 1'b1; // RQ14
		end
		tmr_hold = (s_d.wsm == fcss_pkg::FCSS_WSM_SUSP);
		s_d.rdy  = (s_d.wsm == fcss_pkg::FCSS_WSM_IDLE || s_d.wsm == fcss_pkg::FCSS_WSM_SUSP)
			&& !s_d.sprog; // RQ2
		s_d.susp = (s_d.wsm == fcss_pkg::FCSS_WSM_SUSP); // RQ1
		s_d.sr[fcss_pkg::SR_READY] = s_d.rdy; // RQ2
		s_d.sr[fcss_pkg::SR_SUSP]  = s_d.susp; // RQ1
		// Read data, one cycle after the read strobe
		s_d.rdata = '0;
		if (bus.re) begin
			unique case (s_q.rmode)
				fcss_pkg::FCSS_RD_STATUS: s_d.rdata = {8'h00, s_q.sr};
				fcss_pkg::FCSS_RD_IDENT: begin
					if (bus.addr[fcss_pkg::BLK_LSB-1:0] == fcss_pkg::LOCK_OFS)
						s_d.rdata = {14'h0000, s_q.lock[blk]}; // RQ10
				end
				fcss_pkg::FCSS_RD_ARRAY: begin
					if (!(s_q.wsm == fcss_pkg::FCSS_WSM_SUSP && blk == s_q.op_blk))
						s_d.rdata = 16'hffff; // RQ4
				end
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s_q       <= '0;
			s_q.rmode <= fcss_pkg::FCSS_RD_ARRAY;
			s_q.sr    <= 8'h80;
			s_q.rdy   <= 1'b1;
			s_q.lock  <= {fcss_pkg::NUM_BLK{fcss_pkg::LK_RESET}};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.rdata           = s_q.rdata;
	assign engine_ready_out    = s_q.rdy;
	assign erase_suspended_out = s_q.susp;
endmodule : fcss_device
`default_nettype wire

//--- src/fcss_host.sv
/*
 * Host end: issues one- or two-write command sequences and single-word reads on
 * fcss_bus_if.host, from a simple user request port.
 * Assumes the user holds no request while busy_out is high.
 */
`timescale 1ns/100ps
`default_nettype none
module fcss_host (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	fcss_bus_if.host         bus,
	input  wire logic        req_in,
	input  wire logic        two_in,
	input  wire logic        read_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] data1_in,
	input  wire logic [15:0] data2_in,
	output logic             busy_out,
	output logic             rvalid_out,
	output logic [15:0]      rdata_out
);
	typedef struct packed {
		fcss_pkg::fcss_hstate_t st;
		logic                   two;
		logic [15:0]            addr;
		logic [15:0]            d2;
		logic                   we;
		logic                   re;
		logic [15:0]            a;
		logic [15:0]            wd;
		logic                   busy;
		logic                   rvalid;
		logic [15:0]            rdata;
	} fcss_hst_t;

	fcss_hst_t s_q;
	fcss_hst_t s_d;

	always_comb begin
		s_d        = s_q;
		s_d.we     = 1'b0;
		s_d.re     = 1'b0;
		s_d.rvalid = 1'b0;
		unique case (s_q.st)
			fcss_pkg::FCSS_H_IDLE: begin
				if (req_in) begin
					s_d.two  = two_in;
					s_d.addr = addr_in;
					s_d.d2   = data2_in;
					s_d.a    = addr_in;
					s_d.busy = 1'b1;
					if (read_in) begin
						s_d.re = 1'b1;
						s_d.st = fcss_pkg::FCSS_H_WAIT;
					end else begin
						s_d.we = 1'b1; // RQ7
						s_d.wd = data1_in;
						s_d.st = two_in ? fcss_pkg::FCSS_H_W2 : fcss_pkg::FCSS_H_W1;
					end
				end
			end
			fcss_pkg::FCSS_H_W2: begin
				s_d.we = 1'b1; // RQ16
				s_d.wd = s_q.d2;
				s_d.a  = s_q.addr;
				s_d.st = fcss_pkg::FCSS_H_W1;
			end
			fcss_pkg::FCSS_H_W1: begin
				s_d.busy = 1'b0;
				s_d.st   = fcss_pkg::FCSS_H_IDLE;
			end
			fcss_pkg::FCSS_H_WAIT: s_d.st = fcss_pkg::FCSS_H_RD;
			fcss_pkg::FCSS_H_RD: begin
				s_d.rvalid = 1'b1;
				s_d.rdata  = bus.rdata;
				s_d.busy   = 1'b0;
				s_d.st     = fcss_pkg::FCSS_H_IDLE;
			end
			default: s_d.st = fcss_pkg::FCSS_H_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.we     = s_q.we;
	assign bus.re     = s_q.re;
	assign bus.addr   = s_q.a;
	assign bus.wdata  = s_q.wd;
	assign busy_out   = s_q.busy;
	assign rvalid_out = s_q.rvalid;
	assign rdata_out  = s_q.rdata;
endmodule : fcss_host
`default_nettype wire

//--- src/fcss_pkg.sv
/*
 * Shared constants for the flash command/status sequencer: command codes,
 * status bit positions, address layout, timing counts and state encodings.
 * Assumes a 125 MHz single clock and a synchronous active-low reset.
 */
package fcss_pkg;

	// ****************************************
	// Bus widths and address layout
	// ****************************************
	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 16;
	localparam int BLK_LSB      = 8;
	localparam int PART_LSB     = 12;
	localparam int NUM_BLK      = 16;
	localparam logic [7:0] LOCK_OFS = 8'h02;
	localparam logic [15:0] OTP_BASE = 16'h0080;
	localparam logic [15:0] OTP_TOP  = 16'h0108;
	localparam logic [15:0] OTP_LOCK_ADDR = 16'h0080;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_STATUS_CLEAR = 8'h50;
	localparam logic [7:0] CMD_IDENT_READ   = 8'h90;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
	localparam logic [7:0] CMD_LOCK         = 8'h01;
	localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2f;
	localparam logic [7:0] CMD_OTP_SETUP    = 8'hc0;
	localparam logic [7:0] CMD_BLANK_SETUP  = 8'hbc;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;

	// ****************************************
	// Status word bit positions
	// ****************************************
	localparam int SR_READY   = 7;
	localparam int SR_SUSP    = 6;
	localparam int SR_EBFAIL  = 5;
	localparam int SR_PFAIL   = 4;
	localparam int SR_VPP     = 3;
	localparam int SR_LOCKED  = 1;

	// ****************************************
	// Lock state codes on data bits 1..0
	// ****************************************
	localparam logic [1:0] LK_UNLOCKED = 2'h0;
	localparam logic [1:0] LK_LOCKED   = 2'h1;
	localparam logic [1:0] LK_DOWN     = 2'h3;
	localparam logic [1:0] LK_RESET    = 2'h1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ      = 125;
	localparam int ERASE_NS     = 2000;
	localparam int ERASE_CYC    = (ERASE_NS * CLK_MHZ) / 1000;
	localparam int PROG_NS      = 400;
	localparam int PROG_CYC     = (PROG_NS * CLK_MHZ) / 1000;
	localparam int CNT_W        = 16;

	typedef enum logic [1:0] {
		FCSS_RD_ARRAY  = 2'b00,
		FCSS_RD_STATUS = 2'b01,
		FCSS_RD_IDENT  = 2'b10
	} fcss_rmode_t;

	typedef enum logic [2:0] {
		FCSS_SEQ_IDLE  = 3'b000,
		FCSS_SEQ_ERASE = 3'b001,
		FCSS_SEQ_LOCK  = 3'b010,
		FCSS_SEQ_OTP   = 3'b011,
		FCSS_SEQ_BLANK = 3'b100,
		FCSS_SEQ_PROG  = 3'b101
	} fcss_seq_t;

	typedef enum logic [2:0] {
		FCSS_WSM_IDLE  = 3'b000,
		FCSS_WSM_ERASE = 3'b001,
		FCSS_WSM_SUSP  = 3'b010,
		FCSS_WSM_PROG  = 3'b011,
		FCSS_WSM_OTP   = 3'b100,
		FCSS_WSM_BLANK = 3'b101
	} fcss_wsm_t;

	typedef enum logic [2:0] {
		FCSS_H_IDLE = 3'b000,
		FCSS_H_W1   = 3'b001,
		FCSS_H_W2   = 3'b010,
		FCSS_H_RD   = 3'b011,
		FCSS_H_WAIT = 3'b100
	} fcss_hstate_t;

endpackage : fcss_pkg

//--- src/fcss_timer.sv
/*
 * Down-counting busy timer used by the write state machine.
 * Assumes start and hold are exclusive; hold freezes the count (suspend).
 */
`timescale 1ns/100ps
`default_nettype none
module fcss_timer #(
	parameter int W = 16
) (
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire logic         start_in,
	input  wire logic [W-1:0] load_in,
	input  wire logic         hold_in,
	output logic              done_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
		logic         done;
	} fcss_tmr_t;

	fcss_tmr_t s_q;
	fcss_tmr_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (start_in) begin
			s_d.cnt = load_in;
			s_d.run = 1'b1;
		end else if (s_q.run && !hold_in) begin
			if (s_q.cnt <= W'(1)) begin
				s_d.run  = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_out = s_q.done;
endmodule : fcss_timer
`default_nettype wire

//--- verification/fcss_bus_monitor.sv
/*
 * Checker on the bus joining the flash host and device ends.
 * Assumes tb instantiates it beside fcss_bus_if; one clock, sync low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module fcss_bus_monitor (
	input wire logic        clock_in,
	input wire logic        rst_n_in,
	input wire logic        we,
	input wire logic        re,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        engine_ready_out,
	input wire logic        erase_suspended_out
);
	// ****
	// Helper state
	// ****
	logic       we_q;
	logic [7:0] setup_q;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			we_q    <= 1'b0;
			setup_q <= 8'h00;
		end else begin
			we_q <= we;
			if (we && !we_q && wdata[7:0] inside {8'h20, 8'h60, 8'hc0, 8'hbc}) begin
				setup_q <= wdata[7:0];
			end
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_first(logic [7:0] c);
		we && !we_q && wdata[7:0] == c;
	endsequence
	sequence s_suspend_erase;
		we && wdata[7:0] == 8'hb0 && setup_q == 8'h20 && !engine_ready_out;
	endsequence
	sequence s_resume;
		erase_suspended_out && we && !we_q && wdata[7:0] == 8'hd0;
	endsequence
	property p_rdata_idle; !re |=> rdata == 16'h0000; endproperty
	property p_strobe_excl; !(we && re); endproperty
	property p_erase_pair; s_first(8'h20) |=> we && addr[11:8] == $past(addr[11:8]); endproperty
	property p_lock_pair; s_first(8'h60) |=> we && addr[11:8] == $past(addr[11:8]); endproperty
	property p_blank_pair; s_first(8'hbc) |=> we && addr[11:8] == $past(addr[11:8]); endproperty
	property p_otp_pair; s_first(8'hc0) |=> we; endproperty
	property p_suspend; s_suspend_erase |-> ##[1:3] engine_ready_out; endproperty
	property p_susp_ready; $rose(erase_suspended_out) |-> engine_ready_out; endproperty
	property p_resume; s_resume |-> ##[1:3] (!engine_ready_out && !erase_suspended_out); endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
	a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes high");
	a_erase_pair: assert property (p_erase_pair) else $error("erase confirm missing");
	a_lock_pair: assert property (p_lock_pair) else $error("lock confirm missing");
	a_blank_pair: assert property (p_blank_pair) else $error("blank confirm missing");
	a_otp_pair: assert property (p_otp_pair) else $error("otp data write missing");
	a_suspend: assert property (p_suspend) else $error("suspend not honoured");
	a_susp_ready: assert property (p_susp_ready) else $error("suspended but busy");
	a_resume: assert property (p_resume) else $error("resume not honoured");
endmodule : fcss_bus_monitor
`default_nettype wire

//--- verification/tb.sv
/*
 * Self-checking bench: host and device ends joined by fcss_bus_if.
 * Assumes a 125 MHz clock and shortened erase and program counts.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clock_in, rst_n_in, req, two, rdsel, vpp, pfail, nblank;
	logic        busy, rvalid, ready, susp;
	logic [15:0] addr, d1, d2, rdata;
	int          num_errors, checks;
	fcss_bus_if bus_i ();
	fcss_device #(.ERASE_CYC(40), .PROG_CYC(10)) u_fcss_device (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .bus(bus_i), .vpp_fault_in(vpp), .prog_fail_in(pfail),
		.not_blank_in(nblank), .engine_ready_out(ready), .erase_suspended_out(susp));
	fcss_host u_fcss_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus(bus_i), .req_in(req),
		.two_in(two), .read_in(rdsel), .addr_in(addr), .data1_in(d1), .data2_in(d2),
		.busy_out(busy), .rvalid_out(rvalid), .rdata_out(rdata));
	fcss_bus_monitor u_fcss_bus_monitor (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.we(bus_i.we), .re(bus_i.re), .addr(bus_i.addr), .wdata(bus_i.wdata),
		.rdata(bus_i.rdata), .engine_ready_out(ready), .erase_suspended_out(susp));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	// ****
	// Shared tasks
	// ****
	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic tw, input logic r, input logic [15:0] a,
		input logic [15:0] x, input logic [15:0] y, output logic [15:0] q);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		q = 16'h0000;
		req <= 1'b1;
		two <= tw;
		rdsel <= r;
		addr <= a;
		d1 <= x;
		d2 <= y;
		@(posedge clock_in);
		req <= 1'b0;
		do begin
			@(posedge clock_in);
			if (rvalid === 1'b1) q = rdata;
			if (rvalid === 1'b1 || !r) got = 1'b1;
			n++;
		end while (!(got && busy === 1'b0) && n < 30);
		if (n >= 30) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : op
	task automatic wr1(input logic [15:0] a, input logic [15:0] x);
		logic [15:0] q;
		op(1'b0, 1'b0, a, x, 16'h0000, q);
	endtask : wr1
	task automatic wr2(input logic [15:0] a, input logic [15:0] x, input logic [15:0] y);
		logic [15:0] q;
		op(1'b1, 1'b0, a, x, y, q);
	endtask : wr2
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] q;
		op(1'b0, 1'b1, a, 16'h0000, 16'h0000, q);
		chk(q, exp);
	endtask : rd
	task automatic stat(input logic [15:0] a, input logic [15:0] exp);
		wr1(a, 16'h0070);
		rd(a, exp);
	endtask : stat
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 200) begin
			@(posedge clock_in);
			n++;
		end
		if (n >= 200) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : wait_ready
	task automatic clear_ok();
		wr1(16'h0100, 16'h0050);
		stat(16'h0100, 16'h0080);
	endtask : clear_ok
	// ****
	// Scenarios
	// ****
	task automatic t_lock();
		logic [7:0] code [3];
		logic [1:0] st [3];
		logic [15:0] q;
		code = '{8'hd0, 8'h01, 8'h2f};
		st = '{2'h0, 2'h1, 2'h3};
		for (int i = 0; i < 3; i++) begin
			wr2(16'h0200, 16'h0060, {8'h00, code[i]});
			wr1(16'h0202, 16'h0090);
			op(1'b0, 1'b1, 16'h0202, 16'h0000, 16'h0000, q);
			chk({14'h0, q[1:0]}, {14'h0, st[i]});
		end
		op(1'b0, 1'b1, 16'h0502, 16'h0000, 16'h0000, q);
		chk({14'h0, q[1:0]}, 16'h0001);
		wr1(16'h0200, 16'h00ff);
		rd(16'h0200, 16'hffff);
	endtask : t_lock
	task automatic t_erase();
		wr2(16'h0100, 16'h0060, 16'h00d0);
		wr2(16'h0300, 16'h0060, 16'h00d0);
		wr2(16'h0100, 16'h0020, 16'h00d0);
		stat(16'h0100, 16'h0000);
		wr1(16'h0100, 16'h00b0);
		stat(16'h0100, 16'h00c0);
		wr2(16'h0310, 16'h0040, 16'h1234);
		stat(16'h0100, 16'h0040);
		wait_ready();
		stat(16'h0100, 16'h00c0);
		wr2(16'h0120, 16'h0040, 16'h1234);
		stat(16'h0100, 16'h00f0);
		wr1(16'h0100, 16'h0050);
		wr1(16'h0100, 16'h00ff);
		rd(16'h0100, 16'h0000);
		rd(16'h0300, 16'hffff);
		stat(16'h0100, 16'h00c0);
		wr1(16'h0ff0, 16'h00d0);
		stat(16'h0100, 16'h0000);
		wait_ready();
		stat(16'h0100, 16'h0080);
	endtask : t_erase
	task automatic t_err();
		wr2(16'h0400, 16'h0060, 16'h0055);
		stat(16'h0400, 16'h00b0);
		wr2(16'h0400, 16'h0060, 16'h00d0);
		stat(16'h0400, 16'h00b0);
		clear_ok();
	endtask : t_err
	task automatic otp(input logic [15:0] a, input logic [15:0] x, input logic [15:0] exp);
		wr2(a, 16'h00c0, x);
		wait_ready();
		stat(16'h0100, exp);
	endtask : otp
	task automatic t_otp();
		otp(16'h0090, 16'h1234, 16'h0080);
		pfail <= 1'b1;
		otp(16'h0091, 16'h1234, 16'h0090);
		pfail <= 1'b0;
		clear_ok();
		vpp <= 1'b1;
		otp(16'h0092, 16'h1234, 16'h0088);
		vpp <= 1'b0;
		wr2(16'h0100, 16'h00bc, 16'h00d0);
		stat(16'h0100, 16'h00b8);
		clear_ok();
		otp(16'h0200, 16'h1234, 16'h0090);
		clear_ok();
		otp(16'h0080, 16'h0000, 16'h0080);
		otp(16'h0093, 16'h1234, 16'h0082);
		clear_ok();
	endtask : t_otp
	task automatic t_blank();
		wr2(16'h0100, 16'h00bc, 16'h00d0);
		wait_ready();
		stat(16'h0100, 16'h0080);
		nblank <= 1'b1;
		wr2(16'h0100, 16'h00bc, 16'h00d0);
		wait_ready();
		stat(16'h0100, 16'h00a0);
		nblank <= 1'b0;
		clear_ok();
		wr2(16'h0100, 16'h00bc, 16'h0033);
		wait_ready();
		stat(16'h0100, 16'h00b0);
		clear_ok();
	endtask : t_blank
	initial begin
		{rst_n_in, req, two, rdsel, vpp, pfail, nblank} = 7'h00;
		{addr, d1, d2} = 48'h0;
		num_errors = 0;
		checks = 0;
		repeat (20) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		chk({15'h0, ready}, 16'h0001);
		stat(16'h0100, 16'h0080);
		t_lock();
		t_erase();
		t_err();
		t_otp();
		t_blank();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
